// *** rtl/esfr_pkg.sv ***
// Purpose: Shared constants and types for the sample FIFO readout block.
// Assumes: Byte addressed register port, 32-bit data, serial link mode 0.
// Notes: Offsets, codes, flag bit positions and framing counts live here; buffer depth is a module parameter.
package esfr_pkg;
	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_THRESH = 4'h4;
	localparam logic [3:0] REG_STATUS = 4'h8;
	localparam logic [3:0] REG_BEAT = 4'hc;
	localparam int CTRL_CLR_BIT = 0;
	localparam int CTRL_SYNC_BIT = 1;
	localparam int ST_OVF_BIT = 8;
	localparam int ST_IRQ_BIT = 9;
	localparam logic [5:0] THRESH_RST = 6'h10;
	// ----------------------------------------
	// Link commands and framing counts
	// ----------------------------------------
	localparam logic [7:0] CMD_BURST = 8'h20;
	localparam logic [7:0] CMD_SINGLE = 8'h21;
	localparam logic [7:0] CMD_BEAT = 8'h25;
	localparam logic [5:0] CNT_CMD_LAST = 6'h07;
	localparam logic [5:0] CNT_WORD_LAST = 6'h1f;
	localparam logic [5:0] CNT_BURST_RESTART = 6'h08;
	// ----------------------------------------
	// Word layout and tags
	// ----------------------------------------
	localparam int WORD_W = 24;
	localparam int SAMPLE_W = 18;
	localparam int BEAT_W = 14;
	localparam int ENTRY_FAST_BIT = 0;
	localparam logic [2:0] TAG_VALID = 3'h0;
	localparam logic [2:0] TAG_FAST = 3'h1;
	localparam logic [2:0] TAG_VALID_EOF = 3'h2;
	localparam logic [2:0] TAG_FAST_EOF = 3'h3;
	localparam logic [2:0] TAG_EMPTY = 3'h6;
	localparam logic [2:0] TAG_OVF = 3'h7;
	localparam logic [2:0] LOW_TAG_FILL = 3'h0;
	localparam logic [9:0] BEAT_PAD = 10'h000;
	localparam logic [4:0] ENTRY_PAD = 5'h00;
	// ----------------------------------------
	// Link state
	// ----------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_CMD = 2'h1,
		ST_DATA = 2'h3,
		ST_DONE = 2'h2
	} esfr_state_t;
endpackage

// *** rtl/esfr_sync2.sv ***
// Purpose: Two flip-flop synchroniser for pins from outside the clock domain.
// Assumes: Each bit is an independent level.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/1ps
module esfr_sync2 #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Data
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] sync;
	} esfr_sync_t;
	esfr_sync_t s_q;
	esfr_sync_t s_d;
	always_comb
	begin
		s_d.meta = d;
		s_d.sync = s_q.meta;
	end
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			s_q <= {RST_VAL, RST_VAL};
		end
		else
		begin
			s_q <= s_d;
		end
	end
	assign q = s_q.sync;
endmodule

// *** rtl/esfr_sample_mem.sv ***
// Purpose: Circular sample storage with one write and one read port.
// Assumes: Pointers are managed by the instantiating logic.
// Notes: Read is combinational so a reload can use the next entry at once.
`timescale 1ns/1ps
module esfr_sample_mem #(
	parameter int W = 24,
	parameter int D = 32,
	parameter int AW = $clog2(D)
) (
	// Clock
	input wire logic clk,
	// Write port
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [W-1:0] wdata,
	// Read port
	input wire logic [AW-1:0] raddr,
	output logic [W-1:0] rdata
);
	logic [W-1:0] mem [D];
	always_ff @(posedge clk)
	begin
		if (we)
		begin
			mem[waddr] <= wdata;
		end
	end
	assign rdata = mem[raddr];
endmodule

// *** rtl/esfr_readout.sv ***
// Purpose: Sample FIFO with serial readout, fill threshold and overflow.
// Assumes: Link clock is sampled by clk; host holds each bit for 2+ clk cycles.
// Notes: Register port gives clear, resync, threshold, status and interval.
//
// Summary of operation
// - Circular buffer of 32 entries, 24 bits.
// - Single read advances on 32nd rising edge.
// - Burst advances on edge 32 plus n*24.
// - Advanced entries are never returned again.
// - Write pointer moves on each new sample stored; frozen once overflowed.
// - Fill interrupt when unread count reaches threshold.
// - Wrap onto read pointer flags overflow.
// - Clear or resync command empties buffer.
// - Voltage left justified above six tag bits.
// - Sample tag sits at bits 5:3.
// - Tag 000 marks an ordinary sample.
// - Tag 001 marks a fast recovery sample.
// - Last unread uses tag 010 or 011.
// - Empty buffer read returns tag 110.
// - After overflow words carry tag 111.
// - Burst read 0x20, single read 0x21.
// - Command 0x25 returns interval, ten zero bits.
`timescale 1ns/1ps
module esfr_readout #(
	parameter int DEPTH = 32,
	parameter int PTR_W = $clog2(DEPTH)
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Serial link pins
	input wire logic spi_sclk,
	input wire logic spi_csb_n,
	input wire logic spi_mosi,
	output logic spi_miso,
	output logic spi_miso_oe,
	// Acquisition side
	input wire logic sample_valid,
	input wire logic [esfr_pkg::SAMPLE_W-1:0] sample_voltage,
	input wire logic sample_fast,
	input wire logic beat_valid,
	input wire logic [esfr_pkg::BEAT_W-1:0] beat_interval,
	// Register port
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_we,
	input wire logic reg_re,
	output logic [31:0] reg_rdata,
	// Status outputs
	output logic fill_level_irq,
	output logic buffer_overflow_flag,
	output logic channel_resync_cmd
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		esfr_pkg::esfr_state_t st;
		logic sclk_prev;
		logic [5:0] bit_cnt;
		logic [7:0] cmd;
		logic [esfr_pkg::WORD_W-1:0] shift;
		logic real_word;
		logic miso;
		logic miso_oe;
		logic [PTR_W-1:0] rd_ptr;
		logic [PTR_W-1:0] wr_ptr;
		logic [PTR_W:0] count;
		logic ovf;
		logic [PTR_W:0] thresh;
		logic irq;
		logic [esfr_pkg::BEAT_W-1:0] beat;
		logic [31:0] rdata;
		logic resync;
	} esfr_regs_t;
	esfr_regs_t q;
	esfr_regs_t d;
	logic sclk_s;
	logic csb_n_s;
	logic mosi_s;
	logic rise;
	logic fall;
	logic clr;
	logic full;
	logic adv_now;
	logic wr_en;
	logic set_ovf;
	logic [PTR_W-1:0] raddr;
	logic [esfr_pkg::WORD_W-1:0] entry;
	logic [esfr_pkg::WORD_W-1:0] wentry;
	logic [PTR_W:0] cnt_after;
	// ----------------------------------------
	// Pin synchronisers and sample storage
	// ----------------------------------------
	// Chip select resets high so the output stays released during reset.
	esfr_sync2 #(
		.W(3),
		.RST_VAL(3'h2)
	) u_sync (
		.clk(clk),
		.rst(rst),
		.d({spi_sclk, spi_csb_n, spi_mosi}),
		.q({sclk_s, csb_n_s, mosi_s})
	);
	assign wentry = {sample_voltage, esfr_pkg::ENTRY_PAD, sample_fast};
	esfr_sample_mem #(
		.W(esfr_pkg::WORD_W),
		.D(DEPTH),
		.AW(PTR_W)
	) u_mem (
		.clk(clk),
		.we(wr_en),
		.waddr(q.wr_ptr),
		.wdata(wentry),
		.raddr(raddr),
		.rdata(entry)
	);
	// ----------------------------------------
	// Pointer control terms
	// ----------------------------------------
	assign rise = sclk_s & ~q.sclk_prev;
	assign fall = ~sclk_s & q.sclk_prev;
	assign clr = reg_we && (reg_addr == esfr_pkg::REG_CTRL)
		&& (reg_wdata[esfr_pkg::CTRL_CLR_BIT] || reg_wdata[esfr_pkg::CTRL_SYNC_BIT]);
	assign full = (q.count == (PTR_W+1)'(DEPTH));
	// The final edge of a real word marks it read; empty or overflow words do not.
	assign adv_now = rise && !csb_n_s && (q.st == esfr_pkg::ST_DATA)
		&& (q.bit_cnt == esfr_pkg::CNT_WORD_LAST) && q.real_word
		&& (q.count != '0) && !clr;
	// Once overflowed, storage is frozen until a clear, since order is lost anyway.
	assign wr_en = sample_valid && !clr && !q.ovf && (!full || adv_now);
	assign set_ovf = sample_valid && !q.ovf && full && !adv_now;
	assign raddr = q.rd_ptr + PTR_W'(adv_now);
	assign cnt_after = q.count - (PTR_W+1)'(adv_now);
	// ----------------------------------------
	// Word assembly
	// ----------------------------------------
	function automatic logic [esfr_pkg::WORD_W-1:0] make_word(
		input logic ovf,
		input logic empty,
		input logic last,
		input logic [esfr_pkg::WORD_W-1:0] e
	);
		logic [2:0] tag;
		logic [esfr_pkg::SAMPLE_W-1:0] v;
		v = e[esfr_pkg::WORD_W-1 -: esfr_pkg::SAMPLE_W];
		if (ovf)
		begin
			tag = esfr_pkg::TAG_OVF;
			v = '0;
		end
		else if (empty)
		begin
			tag = esfr_pkg::TAG_EMPTY;
			v = '0;
		end
		else if (last)
		begin
			tag = e[esfr_pkg::ENTRY_FAST_BIT] ? esfr_pkg::TAG_FAST_EOF
				: esfr_pkg::TAG_VALID_EOF;
		end
		else
		begin
			tag = e[esfr_pkg::ENTRY_FAST_BIT] ? esfr_pkg::TAG_FAST
				: esfr_pkg::TAG_VALID;
		end
		return {v, tag, esfr_pkg::LOW_TAG_FILL};
	endfunction
	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb
	begin
		logic [7:0] c;
		logic empty;
		c = {q.cmd[6:0], mosi_s};
		empty = (cnt_after == '0);
		d = q;
		d.sclk_prev = sclk_s;
		d.resync = 1'b0;
		d.rdata = '0;
		// Register writes.
		if (reg_we)
		begin
			unique case (reg_addr)
				esfr_pkg::REG_CTRL:
				begin
					d.resync = reg_wdata[esfr_pkg::CTRL_SYNC_BIT];
				end
				esfr_pkg::REG_THRESH:
				begin
					if (reg_wdata == '0)
					begin
						d.thresh = (PTR_W+1)'(1);
					end
					else if (reg_wdata > 32'(DEPTH))
					begin
						d.thresh = (PTR_W+1)'(DEPTH);
					end
					else
					begin
						d.thresh = reg_wdata[PTR_W:0];
					end
				end
				default:
				begin
				end
			endcase
		end
		// Register reads; unmapped offsets read as zero.
		if (reg_re)
		begin
			unique case (reg_addr)
				esfr_pkg::REG_THRESH:
				begin
					d.rdata[PTR_W:0] = q.thresh;
				end
				esfr_pkg::REG_STATUS:
				begin
					d.rdata[PTR_W:0] = q.count;
					d.rdata[esfr_pkg::ST_OVF_BIT] = q.ovf;
					d.rdata[esfr_pkg::ST_IRQ_BIT] = q.irq;
				end
				esfr_pkg::REG_BEAT:
				begin
					d.rdata[esfr_pkg::BEAT_W-1:0] = q.beat;
				end
				default:
				begin
				end
			endcase
		end
		if (beat_valid)
		begin
			d.beat = beat_interval;
		end
		// Buffer pointers and count.
		if (wr_en)
		begin
			d.wr_ptr = q.wr_ptr + 1'b1;
		end
		if (adv_now)
		begin
			d.rd_ptr = q.rd_ptr + 1'b1;
		end
		d.count = cnt_after + (PTR_W+1)'(wr_en);
		// An overflow in the clear cycle survives the clear.
		d.ovf = q.ovf || set_ovf;
		d.irq = (q.count >= q.thresh);
		// Serial link.
		if (csb_n_s)
		begin
			d.st = esfr_pkg::ST_IDLE;
			d.bit_cnt = '0;
			d.miso = 1'b0;
			d.miso_oe = 1'b0;
			d.real_word = 1'b0;
		end
		else
		begin
			d.miso_oe = 1'b1;
			unique case (q.st)
				esfr_pkg::ST_IDLE:
				begin
					d.st = esfr_pkg::ST_CMD;
					d.bit_cnt = '0;
				end
				esfr_pkg::ST_CMD:
				begin
					if (rise)
					begin
						d.cmd = c;
						d.bit_cnt = q.bit_cnt + 1'b1;
						if (q.bit_cnt == esfr_pkg::CNT_CMD_LAST)
						begin
							d.st = esfr_pkg::ST_DATA;
							d.real_word = 1'b0;
							if (c == esfr_pkg::CMD_BEAT)
							begin
								d.shift = {q.beat, esfr_pkg::BEAT_PAD};
							end
							else if (c == esfr_pkg::CMD_BURST || c == esfr_pkg::CMD_SINGLE)
							begin
								d.shift = make_word(q.ovf, empty, cnt_after == 1, entry);
								d.real_word = !q.ovf && !empty;
							end
							else
							begin
								d.st = esfr_pkg::ST_DONE;
							end
						end
					end
					if (fall)
					begin
						d.miso = 1'b0;
					end
				end
				esfr_pkg::ST_DATA:
				begin
					if (rise)
					begin
						d.bit_cnt = q.bit_cnt + 1'b1;
						if (q.bit_cnt == esfr_pkg::CNT_WORD_LAST)
						begin
							if (q.cmd == esfr_pkg::CMD_BURST)
							begin
								d.shift = make_word(q.ovf, empty, cnt_after == 1, entry);
								d.real_word = !q.ovf && !empty;
								d.bit_cnt = esfr_pkg::CNT_BURST_RESTART;
							end
							else
							begin
								d.st = esfr_pkg::ST_DONE;
								d.real_word = 1'b0;
							end
						end
					end
					if (fall)
					begin
						d.miso = q.shift[esfr_pkg::WORD_W-1];
						d.shift = {q.shift[esfr_pkg::WORD_W-2:0], 1'b0};
					end
				end
				esfr_pkg::ST_DONE:
				begin
					if (fall)
					begin
						d.miso = 1'b0;
					end
				end
			endcase
		end
		// Clear and resync both empty the buffer and stop any word in flight from advancing.
		if (clr)
		begin
			d.rd_ptr = '0;
			d.wr_ptr = '0;
			d.count = '0;
			d.ovf = set_ovf;
			d.real_word = 1'b0;
		end
	end
	// ----------------------------------------
	// Registers and outputs
	// ----------------------------------------
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			q <= '0;
			q.thresh <= (PTR_W+1)'(esfr_pkg::THRESH_RST);
		end
		else
		begin
			q <= d;
		end
	end
	assign spi_miso = q.miso;
	assign spi_miso_oe = q.miso_oe;
	assign reg_rdata = q.rdata;
	assign fill_level_irq = q.irq;
	assign buffer_overflow_flag = q.ovf;
	assign channel_resync_cmd = q.resync;
endmodule

// *** sim/esfr_readout_checker.sv ***
// Purpose: Port level checks for the sample FIFO readout.
// Assumes: Only the top ports are visible.
// Notes: The threshold is mirrored here since no port shows it.
`timescale 1ns/1ps
module esfr_readout_checker #(
	parameter int DEPTH = 32,
	parameter int PTR_W = 5
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Link
	input wire logic spi_csb_n,
	input wire logic spi_miso,
	input wire logic spi_miso_oe,
	// Samples and registers
	input wire logic sample_valid,
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_we,
	input wire logic reg_re,
	input wire logic [31:0] reg_rdata,
	// Status
	input wire logic fill_level_irq,
	input wire logic buffer_overflow_flag,
	input wire logic channel_resync_cmd
);
	logic [5:0] thr_q;
	logic [5:0] thr_d;
	wire logic ctl_w = reg_we && reg_addr == esfr_pkg::REG_CTRL;
	wire logic clr_w = ctl_w && reg_wdata[1:0] != 2'h0;
	// Clamped mirror, so a readback of 0 or 33 cannot slip through.
	always_comb
	begin
		thr_d = thr_q;
		if (reg_we && reg_addr == esfr_pkg::REG_THRESH)
		begin
			thr_d = reg_wdata == 0 ? 6'h01 : reg_wdata > 32 ? 6'h20 : reg_wdata[5:0];
		end
	end
	always_ff @(posedge clk)
	begin
		thr_q <= rst ? esfr_pkg::THRESH_RST : thr_d;
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	sequence clr_quiet_s;
		clr_w && !sample_valid ##1 !sample_valid;
	endsequence
	ovf_sticky_a: assert property (buffer_overflow_flag && !clr_w |=> buffer_overflow_flag)
		else $error("overflow flag dropped");
	clear_ovf_a: assert property (clr_w && !sample_valid |=> !buffer_overflow_flag)
		else $error("clear left overflow");
	clear_irq_a: assert property (clr_quiet_s |=> !fill_level_irq)
		else $error("fill irq after clear");
	resync_pulse_a: assert property (
		channel_resync_cmd == $past(ctl_w && reg_wdata[1]))
		else $error("resync pulse wrong");
	thr_read_a: assert property (
		reg_re && reg_addr == esfr_pkg::REG_THRESH |=> reg_rdata == {26'h0, $past(thr_q)})
		else $error("threshold readback wrong");
	stat_flags_a: assert property (
		reg_re && reg_addr == esfr_pkg::REG_STATUS |=> reg_rdata[9] == $past(fill_level_irq)
		&& reg_rdata[8] == $past(buffer_overflow_flag))
		else $error("status flags differ");
	oe_frame_a: assert property ((!spi_csb_n) [*4] |-> spi_miso_oe)
		else $error("output enable low in frame");
	oe_idle_a: assert property (spi_csb_n [*4] |-> !spi_miso_oe)
		else $error("output enable high outside frame");
	miso_quiet_a: assert property ((!spi_miso_oe) [*2] |-> !spi_miso)
		else $error("data pin active while idle");
endmodule
bind esfr_readout esfr_readout_checker #(.DEPTH(DEPTH), .PTR_W(PTR_W)) u_chk (
	.clk(clk), .rst(rst), .spi_csb_n(spi_csb_n), .spi_miso(spi_miso),
	.spi_miso_oe(spi_miso_oe), .sample_valid(sample_valid), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
	.fill_level_irq(fill_level_irq), .buffer_overflow_flag(buffer_overflow_flag),
	.channel_resync_cmd(channel_resync_cmd));

// *** sim/esfr_host_model.sv ***
// Purpose: Host controller that runs frames on the serial link.
// Assumes: Clock idles low, data sampled on rise, most significant bit first.
// Notes: Words are queued for the bench; mosi toggles when unused.
`timescale 1ns/1ps
module esfr_host_model (
	// Link pins
	output logic spi_sclk,
	output logic spi_csb_n,
	output logic spi_mosi,
	input wire logic spi_miso
);
	logic [23:0] rx[$];
	int time_base = 0;
	initial
	begin
		spi_sclk = 0;
		spi_csb_n = 1;
		spi_mosi = 0;
	end
	task automatic xfer(input logic [7:0] cmd, input int nw);
		logic [23:0] w;
		w = '0;
		#1;
		spi_csb_n = 0;
		#32;
		for (int i = 0; i < 8 + 24 * nw; i++)
		begin
			spi_mosi = i < 8 ? cmd[7 - i] : ~spi_mosi;
			#16;
			w = {w[22:0], spi_miso};
			spi_sclk = 1;
			#16;
			spi_sclk = 0;
			if (i > 7 && (i - 8) % 24 == 23)
			begin
				rx.push_back(w);
				time_base += int'(w[5:3] < 3'h4);
			end
		end
		#16;
		spi_csb_n = 1;
		spi_mosi = ~spi_mosi;
		#40;
	endtask
endmodule

// *** sim/tb_top.sv ***
// Purpose: Self-checking bench for the sample FIFO readout.
// Assumes: The host model runs the link; the bench drives the rest.
// Notes: A queue model predicts every sample word and status read.
`timescale 1ns/1ps
module tb_top;
	logic clk = 0;
	logic rst = 1;
	logic sample_valid = 0, sample_fast = 0, beat_valid = 0, reg_we = 0, reg_re = 0;
	logic [17:0] sample_voltage = '0;
	logic [13:0] beat_interval = '0;
	logic [13:0] b;
	logic [3:0] reg_addr = '0;
	logic [31:0] reg_wdata = '0;
	logic [31:0] reg_rdata;
	logic fill_level_irq, buffer_overflow_flag, channel_resync_cmd, ovf = 0;
	wire logic sclk, csb_n, mosi, miso, miso_oe;
	int n_errors = 0, checks = 0, thr = 16;
	int tv[5] = '{0, 40, 32, 1, 5};
	logic [18:0] q[$];
	always #2 clk = ~clk;
	esfr_host_model host (.spi_sclk(sclk), .spi_csb_n(csb_n), .spi_mosi(mosi), .spi_miso(miso));
	esfr_readout dut (.clk(clk), .rst(rst), .spi_sclk(sclk), .spi_csb_n(csb_n),
		.spi_mosi(mosi), .spi_miso(miso), .spi_miso_oe(miso_oe), .sample_valid(sample_valid),
		.sample_voltage(sample_voltage), .sample_fast(sample_fast), .beat_valid(beat_valid),
		.beat_interval(beat_interval), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
		.fill_level_irq(fill_level_irq), .buffer_overflow_flag(buffer_overflow_flag),
		.channel_resync_cmd(channel_resync_cmd));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_we <= 1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_we <= 0;
	endtask
	task automatic reg_rd(input logic [3:0] a, input logic [31:0] e);
		@(posedge clk);
		reg_re <= 1;
		reg_addr <= a;
		@(posedge clk);
		reg_re <= 0;
		#1;
		chk(reg_rdata, e);
	endtask
	task automatic st();
		reg_rd(esfr_pkg::REG_STATUS, {22'h0, q.size() >= thr, ovf, 2'h0, 6'(q.size())});
		chk({31'h0, fill_level_irq}, {31'h0, q.size() >= thr});
		chk({31'h0, buffer_overflow_flag}, {31'h0, ovf});
	endtask
	task automatic push(input int n, input logic f);
		logic [17:0] v;
		for (int i = 0; i < n; i++)
		begin
			v = 18'($urandom);
			@(posedge clk);
			sample_valid <= 1;
			sample_voltage <= v;
			sample_fast <= f ^ i[0];
			if (!ovf && q.size() == 32)
				ovf = 1;
			else if (!ovf)
				q.push_back({v, f ^ i[0]});
		end
		@(posedge clk);
		sample_valid <= 0;
	endtask
	task automatic rd(input logic [7:0] c, input int n);
		logic [18:0] e;
		logic [23:0] w;
		host.xfer(c, n);
		repeat (n)
		begin
			w = host.rx.pop_front();
			if (ovf)
				chk(32'(w), 32'h38);
			else if (q.size() == 0)
				chk(32'(w), 32'h30);
			else
			begin
				e = q.pop_front();
				chk(32'(w), {8'h0, e[18:1], 1'b0, q.size() == 0, e[0], 3'h0});
			end
		end
	endtask
	task automatic end_of_test();
		$display("checks=%0d n_errors=%0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial
	begin
		repeat (100000) @(posedge clk);
		n_errors++;
		end_of_test();
	end
	initial
	begin
		void'($urandom(50));
		repeat (5) @(posedge clk);
		rst <= 0;
		repeat (4) @(posedge clk);
		for (int a = 0; a < 16; a++)
			reg_rd(a[3:0], a == 4 ? 32'h10 : 32'h0);
		rd(esfr_pkg::CMD_SINGLE, 1);
		st();
		foreach (tv[i])
		begin
			reg_wr(esfr_pkg::REG_THRESH, tv[i]);
			thr = tv[i] < 1 ? 1 : tv[i] > 32 ? 32 : tv[i];
			reg_rd(esfr_pkg::REG_THRESH, 32'(thr));
		end
		push(7, 0);
		st();
		rd(esfr_pkg::CMD_SINGLE, 1);
		st();
		rd(esfr_pkg::CMD_BURST, 6);
		st();
		for (int k = 0; k < 2; k++)
		begin
			push(1, k[0]);
			rd(esfr_pkg::CMD_SINGLE, 1);
		end
		for (int k = 1; k < 3; k++)
		begin
			push(33, 0);
			st();
			rd(esfr_pkg::CMD_BURST, 2);
			reg_wr(esfr_pkg::REG_CTRL, k);
			q.delete();
			ovf = 0;
			st();
		end
		// Nine real samples were read so far; empty and overflow words add no time step.
		chk(32'(host.time_base), 32'h9);
		b = 14'($urandom);
		@(posedge clk);
		beat_valid <= 1;
		beat_interval <= b;
		@(posedge clk);
		beat_valid <= 0;
		host.xfer(esfr_pkg::CMD_BEAT, 1);
		chk(32'(host.rx.pop_front()), {8'h0, b, 10'h0});
		reg_rd(esfr_pkg::REG_BEAT, 32'(b));
		end_of_test();
	end
endmodule
